// ===== core/ccdfe_pkg.sv
// Package for the CCD front-end gain steering block.
// Assumes one 100 MHz master clock and a word-wide Avalon-MM register bus.
package ccdfe_pkg;
  // Clock rate and timing
  localparam int CLK_MHZ = 100;
  localparam int HCNT_RESET_DELAY = 7;
  localparam logic [2:0] HDLY_LOAD = 3'(HCNT_RESET_DELAY - 1);

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_OPR_MODE = 8'h00;
  localparam logic [7:0] IDX_AFE_CTL = 8'h01;
  localparam logic [7:0] IDX_AFE_OPER = 8'h02;
  localparam logic [7:0] IDX_MODE_SEL = 8'h03;
  localparam logic [7:0] IDX_CLAMP_LVL = 8'h04;
  localparam logic [7:0] IDX_VGA_GAIN = 8'h05;
  localparam logic [7:0] IDX_GAIN_LOW = 8'h06;
  localparam logic [7:0] IDX_GAIN_HIGH = 8'h07;
  localparam logic [7:0] IDX_STATUS = 8'h08;
  localparam logic [7:0] IDX_SAMPLE = 8'h63;

  // Field positions
  localparam int OPR_CLAMP_OFF = 2;
  localparam int OPR_RATE_LSB = 6;
  localparam int CTL_TRISTATE = 3;
  localparam int CTL_TRANSP = 4;
  localparam int CTL_GRAY = 5;
  localparam int CTL_PHASE_LSB = 6;
  localparam int OPER_SGAIN_LSB = 10;
  localparam int SAMP_SIG_LSB = 6;

  // Values after reset
  localparam logic [15:0] RST_OPR = 16'h0000;
  localparam logic [15:0] RST_CTL = 16'h0000;
  localparam logic [15:0] RST_OPER = 16'h0000;
  localparam logic [7:0] RST_CLAMP = 8'h00;
  localparam logic [9:0] RST_VGA = 10'h000;
  localparam logic [17:0] RST_GAIN = 18'h00000;
  localparam logic [11:0] RST_SAMPLE = 12'h000;

  // Gain arithmetic in units of 0.0001 dB
  localparam logic [19:0] VGA_STEP = 20'h0015f;
  localparam logic [19:0] VGA_BASE = 20'h0ea60;
  localparam logic [19:0] COLOR_MUL = 20'h015f9;
  localparam logic [19:0] GAIN_LIMIT = 20'h668a0;
  localparam int CLAMP_SHIFT = 4;

  // Steering modes and sampler gain codes
  typedef enum logic [1:0] {MODE_PROG, MODE_INTER, MODE_THREE, MODE_SPARE} ccdfe_mode_t;
  typedef enum logic [1:0] {SG_0DB, SG_M2DB, SG_M4DB} ccdfe_sgain_t;

  // Gain outputs toward the amplifier chain
  typedef struct packed {
    logic [8:0] color_code;
    logic [1:0] color_sel;
    logic [9:0] vga_code;
    logic [18:0] total_gain;
    logic clipped;
    ccdfe_sgain_t sampler_gain;
  } ccdfe_gain_t;
endpackage : ccdfe_pkg

// ===== core/ccdfe_top.sv
// Control logic of a CCD analog front end: steering, gains, clamp, output.
// Assumes sync and clamp pins asynchronous, converter data on the master clock.
// Notes on behaviour
// - Two-bit field picks sampler gain: 0, -2, -4, 0 dB.
// - Four colour gains, one chosen per pixel by the steering mode.
// - Progressive: vertical sync fall returns steering to gain 0/1 line.
// - Progressive and three-field: horizontal sync fall swaps 0/1 and 2/3 lines.
// - Progressive: vertical sync fall clears field counter.
// - Interlaced: vertical sync fall toggles field counter 0/1.
// - Interlaced: each line starts on 0/1 for field 0, 2/3 for field 1.
// - Three-field: vertical sync fall steps field counter 0, 1, 2.
// - Three-field: fields 0 and 2 start 0/1 line, field 1 starts 2/3.
// - Colour gains are 9-bit codes, two per register.
// - Variable gain 10-bit code, 0.0351 dB per step plus 6 dB.
// - Total gain above 42 dB is clipped to 42 dB.
// - In black interval, filter error against clamp level, feed a DAC correction.
// - Clamp-off bit stops the loop; clamp level becomes a plain offset.
// - Clamp updates once per line, or every few lines if chosen.
// - Output latched at output phase, or transparent when bit set.
// - Tristate bit disables the data outputs.
// - Output binary by default, gray code when bit set.
// - Sample edges placed by sample register, reference before signal.
// - Pixel counter resets seven clocks after horizontal fall; steering follows.
//
// Implementation choices: register access over Avalon-MM and the address map.
module ccdfe_top import ccdfe_pkg::*; #(
  parameter int DATA_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sync and clamp pins
  input wire logic vertical_sync,
  input wire logic horizontal_sync,
  input wire logic black_clamp_pulse,
  // Converter side
  input wire logic [DATA_W-1:0] adc_data,
  output logic [13:0] clamp_dac,
  output ccdfe_gain_t gain_out,
  output logic [5:0] reference_sample_clock,
  output logic [5:0] signal_sample_clock,
  output logic [5:0] out_latch_phase,
  output logic [11:0] pixel_count,
  output logic [1:0] field_counter,
  // Data outputs toward the image processor
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);

  typedef struct packed {
    logic vs_s1, vs_s2, vs_prev;
    logic hs_s1, hs_s2, hs_prev;
    logic cp_s1, cp_s2, cp_prev;
    logic [15:0] opr, ctl, oper;
    ccdfe_mode_t mode;
    logic [7:0] clamp_lvl;
    logic [9:0] vga;
    logic [17:0] gain_low, gain_high;
    logic [11:0] samp;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] hdly;
    logic [11:0] pix_cnt;
    logic [1:0] field;
    logic pattern;
    logic parity;
    logic signed [19:0] err_acc;
    logic signed [13:0] corr;
    logic [2:0] line_cnt;
    logic [13:0] dac;
    logic [DATA_W-1:0] stage1, dout;
    logic oe;
    ccdfe_gain_t gain;
    logic [5:0] ref_ph, sig_ph;
  } ccdfe_state_t;

  ccdfe_state_t st_q, st_d;
  logic rst_s1_q, rst_s2_q;
  logic rst_n;

  function automatic ccdfe_sgain_t sgain_decode(input logic [1:0] code);
    unique case (code)
      2'b01: sgain_decode = SG_M2DB;
      2'b10: sgain_decode = SG_M4DB;
      default: sgain_decode = SG_0DB;
    endcase
  endfunction : sgain_decode

  function automatic logic [19:0] raw_gain(input logic [8:0] color, input logic [9:0] vga);
    logic [31:0] c;
    logic [31:0] v;
    c = (32'(color) * 32'(COLOR_MUL)) >> 4;
    v = 32'(vga) * 32'(VGA_STEP) + 32'(VGA_BASE);
    raw_gain = 20'(c + v);
  endfunction : raw_gain

  function automatic logic [DATA_W-1:0] to_gray(input logic [DATA_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  logic req;
  logic [7:0] idx;
  logic vs_fall, hs_fall, cp_fall, cnt_reset;
  logic [19:0] raw;
  logic [8:0] color_now;
  logic [1:0] sel_now;
  logic signed [13:0] err;
  logic signed [19:0] corr_next;
  logic [DATA_W-1:0] fmt;
  logic [2:0] rate_mask;

  assign req = avs_read | avs_write;
  assign idx = avs_address[9:2];
  assign vs_fall = st_q.vs_prev & ~st_q.vs_s2;
  assign hs_fall = st_q.hs_prev & ~st_q.hs_s2;
  assign cp_fall = st_q.cp_prev & ~st_q.cp_s2;
  assign cnt_reset = (st_q.hdly == 3'h1);

  always_comb begin
    st_d = st_q;
    // Synchronisers and edge history
    st_d.vs_s1 = vertical_sync;
    st_d.vs_s2 = st_q.vs_s1;
    st_d.vs_prev = st_q.vs_s2;
    st_d.hs_s1 = horizontal_sync;
    st_d.hs_s2 = st_q.hs_s1;
    st_d.hs_prev = st_q.hs_s2;
    st_d.cp_s1 = black_clamp_pulse;
    st_d.cp_s2 = st_q.cp_s1;
    st_d.cp_prev = st_q.cp_s2;

    // Bus: capture on first edge, answer on second
    st_d.ack = req & ~st_q.ack;
    if (req && !st_q.ack) begin
      unique case (idx)
        IDX_OPR_MODE: st_d.rdata = {16'h0000, st_q.opr};
        IDX_AFE_CTL: st_d.rdata = {16'h0000, st_q.ctl};
        IDX_AFE_OPER: st_d.rdata = {16'h0000, st_q.oper};
        IDX_MODE_SEL: st_d.rdata = {30'h0, st_q.mode};
        IDX_CLAMP_LVL: st_d.rdata = {24'h0, st_q.clamp_lvl};
        IDX_VGA_GAIN: st_d.rdata = {22'h0, st_q.vga};
        IDX_GAIN_LOW: st_d.rdata = {14'h0, st_q.gain_low};
        IDX_GAIN_HIGH: st_d.rdata = {14'h0, st_q.gain_high};
        IDX_STATUS: st_d.rdata = {2'h0, st_q.corr, st_q.gain.clipped, st_q.gain.color_sel,
                                  st_q.field, st_q.pix_cnt[10:0]};
        IDX_SAMPLE: st_d.rdata = {20'h0, st_q.samp};
        default: st_d.rdata = 32'h0;
      endcase
    end
    if (avs_write && st_q.ack) begin
      unique case (idx)
        IDX_OPR_MODE: st_d.opr = avs_writedata[15:0];
        IDX_AFE_CTL: st_d.ctl = avs_writedata[15:0];
        IDX_AFE_OPER: st_d.oper = avs_writedata[15:0];
        IDX_MODE_SEL: st_d.mode = ccdfe_mode_t'(avs_writedata[1:0]);
        IDX_CLAMP_LVL: st_d.clamp_lvl = avs_writedata[7:0];
        IDX_VGA_GAIN: st_d.vga = avs_writedata[9:0];
        IDX_GAIN_LOW: st_d.gain_low = avs_writedata[17:0];
        IDX_GAIN_HIGH: st_d.gain_high = avs_writedata[17:0];
        IDX_SAMPLE: st_d.samp = avs_writedata[11:0];
        default: st_d.ctl = st_q.ctl;
      endcase
    end

    // Pixel counter reset delayed after horizontal fall
    if (hs_fall) begin
      st_d.hdly = HDLY_LOAD;
    end else if (st_q.hdly != 3'h0) begin
      st_d.hdly = st_q.hdly - 3'h1;
    end
    if (cnt_reset) begin
      st_d.pix_cnt = 12'h000;
    end else if (st_q.pix_cnt != 12'hfff) begin
      st_d.pix_cnt = st_q.pix_cnt + 12'h001;
    end

    // Per-pixel alternation, even gain at counter reset
    st_d.parity = cnt_reset ? 1'b0 : ~st_q.parity;

    // Line pattern at counter reset
    if (cnt_reset) begin
      if (st_q.mode == MODE_INTER) begin
        st_d.pattern = st_q.field[0];
      end else begin
        st_d.pattern = ~st_q.pattern;
      end
    end

    // Field counter on vertical fall
    if (vs_fall) begin
      unique case (st_q.mode)
        MODE_INTER: begin
          st_d.field = {1'b0, ~st_q.field[0]};
          st_d.pattern = ~st_q.field[0];
        end
        MODE_THREE: begin
          st_d.field = (st_q.field >= 2'd2) ? 2'd0 : st_q.field + 2'd1;
          st_d.pattern = (st_q.field == 2'd0);
        end
        default: begin
          st_d.field = 2'd0;
          st_d.pattern = 1'b0;
        end
      endcase
    end

    // Gain steering and clipping
    sel_now = {st_q.pattern, st_q.parity};
    unique case (sel_now)
      2'd0: color_now = st_q.gain_low[8:0];
      2'd1: color_now = st_q.gain_low[17:9];
      2'd2: color_now = st_q.gain_high[8:0];
      default: color_now = st_q.gain_high[17:9];
    endcase
    raw = raw_gain(color_now, st_q.vga);
    st_d.gain.color_code = color_now;
    st_d.gain.color_sel = sel_now;
    st_d.gain.vga_code = st_q.vga;
    st_d.gain.clipped = raw > GAIN_LIMIT;
    st_d.gain.total_gain = (raw > GAIN_LIMIT) ? GAIN_LIMIT[18:0] : raw[18:0];
    st_d.gain.sampler_gain = sgain_decode(st_q.oper[OPER_SGAIN_LSB +: 2]);

    // Black clamp loop
    err = 14'(signed'({6'h0, st_q.clamp_lvl})) - 14'(signed'({2'b0, adc_data}));
    rate_mask = 3'((4'h1 << st_q.opr[OPR_RATE_LSB +: 2]) - 4'h1);
    corr_next = 20'(st_q.corr) + (st_q.err_acc >>> CLAMP_SHIFT);
    if (st_q.opr[OPR_CLAMP_OFF]) begin
      st_d.err_acc = 20'sh0;
      st_d.dac = {6'h0, st_q.clamp_lvl};
    end else begin
      if (st_q.cp_s2) begin
        st_d.err_acc = st_q.err_acc + 20'(err);
      end
      if (cp_fall) begin
        st_d.err_acc = 20'sh0;
        st_d.line_cnt = st_q.line_cnt + 3'h1;
        if ((st_q.line_cnt & rate_mask) == 3'h0) begin
          if (corr_next > 20'sh01fff) begin
            st_d.corr = 14'sh1fff;
          end else if (corr_next < -20'sh02000) begin
            st_d.corr = -14'sh2000;
          end else begin
            st_d.corr = corr_next[13:0];
          end
        end
      end
      st_d.dac = st_q.corr;
    end

    // Sample edge placement, signal after reference
    st_d.ref_ph = st_q.samp[5:0];
    if (st_q.samp[SAMP_SIG_LSB +: 6] > st_q.samp[5:0] || st_q.samp[5:0] == 6'h3f) begin
      st_d.sig_ph = st_q.samp[SAMP_SIG_LSB +: 6];
    end else begin
      st_d.sig_ph = st_q.samp[5:0] + 6'h01;
    end

    // Output coding, latch and enable
    fmt = st_q.ctl[CTL_GRAY] ? to_gray(adc_data) : adc_data;
    st_d.stage1 = fmt;
    st_d.dout = st_q.ctl[CTL_TRANSP] ? fmt : st_q.stage1;
    st_d.oe = ~st_q.ctl[CTL_TRISTATE];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.opr <= RST_OPR;
      st_q.ctl <= RST_CTL;
      st_q.oper <= RST_OPER;
      st_q.mode <= MODE_PROG;
      st_q.clamp_lvl <= RST_CLAMP;
      st_q.vga <= RST_VGA;
      st_q.gain_low <= RST_GAIN;
      st_q.gain_high <= RST_GAIN;
      st_q.samp <= RST_SAMPLE;
      st_q.ref_ph <= RST_SAMPLE[5:0];
      st_q.sig_ph <= RST_SAMPLE[5:0] + 6'h01;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest = req & ~st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign clamp_dac = st_q.dac;
  assign gain_out = st_q.gain;
  assign reference_sample_clock = st_q.ref_ph;
  assign signal_sample_clock = st_q.sig_ph;
  assign out_latch_phase = st_q.ctl[CTL_PHASE_LSB +: 6];
  assign pixel_count = st_q.pix_cnt;
  assign field_counter = st_q.field;
  assign data_out = st_q.dout;
  assign data_oe = st_q.oe;

  // Checks
  sequence hs_edge_s;
    hs_fall && st_q.hdly == 3'h0;
  endsequence
  sequence quiet_line_s;
    !hs_fall [*6];
  endsequence

  cnt_reset_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hs_edge_s ##1 quiet_line_s |=> st_q.pix_cnt == 12'h000 && !st_q.parity)
    else $error("pixel counter not reset seven clocks after sync fall");
  pixel_alternate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cnt_reset |=> st_q.parity != $past(st_q.parity))
    else $error("steering did not alternate");
  field_prog_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    vs_fall && st_q.mode == MODE_PROG |=> st_q.field == 2'd0 && !st_q.pattern)
    else $error("progressive field not cleared");
  field_inter_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    vs_fall && st_q.mode == MODE_INTER |=> st_q.field == {1'b0, ~$past(st_q.field[0])})
    else $error("interlaced field not toggled");
  field_three_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    vs_fall && st_q.mode == MODE_THREE && st_q.field == 2'd2 |=> st_q.field == 2'd0)
    else $error("three-field counter not wrapped");
  line_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cnt_reset && !vs_fall && st_q.mode == MODE_INTER |=> st_q.pattern == st_q.field[0])
    else $error("interlaced line start wrong");
  gain_clip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.gain.clipped |-> st_q.gain.total_gain == GAIN_LIMIT[18:0])
    else $error("total gain not clipped");
  edge_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.sig_ph > st_q.ref_ph || st_q.ref_ph == 6'h3f)
    else $error("signal sample not after reference");
  tristate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.ctl[CTL_TRISTATE] |=> !data_oe)
    else $error("outputs driven while tristated");
  bus_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    avs_waitrequest |=> !avs_waitrequest || !req)
    else $error("bus answer late");
  sampler_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.oper[OPER_SGAIN_LSB +: 2] == 2'b11 |=> st_q.gain.sampler_gain == SG_0DB)
    else $error("sampler gain code 3 not 0 dB");
  line_swap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cnt_reset && !vs_fall && st_q.mode != MODE_INTER |=> st_q.pattern != $past(st_q.pattern))
    else $error("line pattern did not swap");
  field_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    vs_fall && st_q.mode == MODE_THREE && st_q.field < 2'd2 |=> st_q.field == $past(st_q.field) + 2'd1)
    else $error("three-field counter not advanced");
  three_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    vs_fall && st_q.mode == MODE_THREE |=> st_q.pattern == (st_q.field == 2'd1))
    else $error("three-field start pattern wrong");
  clamp_offset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.opr[OPR_CLAMP_OFF] |=> clamp_dac == {6'h0, $past(st_q.clamp_lvl)})
    else $error("clamp level not applied as offset");
  clamp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cp_fall |=> $stable(st_q.corr))
    else $error("clamp correction moved between updates");
  transparent_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.ctl[CTL_TRANSP] && !st_q.ctl[CTL_GRAY] |=> data_out == $past(adc_data))
    else $error("transparent output not passed through");
endmodule : ccdfe_top

// ===== test/ccdfe_far_end.sv
// Far-side model: CCD timing source and converter words.
// Assumes its tasks are called right after a rising clock edge.
module ccdfe_far_end #(
  parameter int DATA_W = 12
) (
  // Clock and level choice
  input wire logic sys_clk,
  input wire logic adc_low,
  // Pins toward the front end
  output logic vertical_sync,
  output logic horizontal_sync,
  output logic black_clamp_pulse,
  output logic [DATA_W-1:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int hlow = 0;
  int vlow = 0;
  int hpos = 0;
  initial begin
    vertical_sync = 1'b1;
    horizontal_sync = 1'b1;
    black_clamp_pulse = 1'b0;
    adc_data = '0;
  end
  // Sync falls start a line or a field
  task automatic hfall();
    horizontal_sync <= 1'b0;
  endtask : hfall
  task automatic vfall();
    vertical_sync <= 1'b0;
  endtask : vfall
  // Pins rise after four low cycles; clamp pulse spans 22 pixels
  always @(posedge sys_clk) begin
    hlow <= horizontal_sync ? 0 : hlow + 1;
    vlow <= vertical_sync ? 0 : vlow + 1;
    hpos <= horizontal_sync ? hpos + 1 : 0;
    if (hlow == 3) begin
      horizontal_sync <= 1'b1;
    end
    if (vlow == 3) begin
      vertical_sync <= 1'b1;
    end
    black_clamp_pulse <= hpos >= 8 && hpos < 30;
    adc_data <= adc_low ? DATA_W'($urandom_range(15)) : DATA_W'($urandom);
  end
endmodule : ccdfe_far_end

// ===== test/test_ccdfe_frontend_gain_steering.sv
// Bench for the CCD front-end gain steering block.
// Assumes the far-side model ccdfe_far_end and one 100 MHz clock.
module test_ccd_frontend_gain_steering import ccdfe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdv;
  logic avs_waitrequest, vs, hs, clp, data_oe, ep, p;
  logic adc_low = 1'b0;
  logic [11:0] adc, dout, pix, h0, h1, h2;
  logic [13:0] clamp_dac, d0, d1, d2;
  ccdfe_gain_t gain_out;
  logic [5:0] ref_ck, sig_ck, phs, phs_o, r, s;
  logic [1:0] fld, ef;
  logic [8:0] g [4];
  logic [8:0] c;
  logic [9:0] v;
  int errors = 0;
  int compares = 0;
  int tot;
  always #5 sys_clk = ~sys_clk;
  ccdfe_top ccdfe_top_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .vertical_sync(vs), .horizontal_sync(hs),
    .black_clamp_pulse(clp), .adc_data(adc), .clamp_dac(clamp_dac), .gain_out(gain_out),
    .reference_sample_clock(ref_ck), .signal_sample_clock(sig_ck), .out_latch_phase(phs_o),
    .pixel_count(pix), .field_counter(fld), .data_out(dout), .data_oe(data_oe)
  );
  ccdfe_far_end ccdfe_far_end_inst (
    .sys_clk(sys_clk), .adc_low(adc_low), .vertical_sync(vs), .horizontal_sync(hs),
    .black_clamp_pulse(clp), .adc_data(adc)
  );
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [11:0] enc(input logic [11:0] b, input logic gy);
    return gy ? b ^ (b >> 1) : b;
  endfunction : enc
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // Avalon-MM cycle, held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] i, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {i, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk("bus answer", 1, n < 20);
    if (n >= 20) begin
      end_of_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, i, d, x);
  endtask : wr
  // One line: counter reset delay, parity and gain choice
  task automatic line(output logic pt);
    int n;
    n = 0;
    @(posedge sys_clk);
    ccdfe_far_end_inst.hfall();
    do begin
      cyc(1);
      n++;
    end while (pix !== 12'h000 && n < 20);
    chk("reset delay", 32'(HCNT_RESET_DELAY + 2), n);
    if (n >= 20) begin
      end_of_test();
    end
    cyc(1);
    pt = gain_out.color_sel[1];
    chk("parity first", 0, gain_out.color_sel[0]);
    chk("pixel count", 1, pix);
    chk("color code", g[gain_out.color_sel], gain_out.color_code);
    cyc(1);
    chk("parity next", {pt, 1'b1}, gain_out.color_sel);
    cyc(32);
  endtask : line
  task automatic vframe(input logic [1:0] f, input logic sp);
    @(posedge sys_clk);
    ccdfe_far_end_inst.vfall();
    cyc(8);
    chk("field", f, fld);
    chk("field pattern", sp, gain_out.color_sel[1]);
  endtask : vframe
  initial begin
    void'($urandom(32'h4eccfdaa));
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    cyc(4);
    bus(1'b0, IDX_VGA_GAIN, 32'h0, rdv);
    chk("vga reset", 32'(RST_VGA), rdv);
    wr(8'h20, 32'hffff);
    bus(1'b0, 8'h20, 32'h0, rdv);
    chk("unmapped", 0, rdv);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_AFE_OPER, 32'(k) << OPER_SGAIN_LSB);
      cyc(3);
      chk("sampler gain", (k == 3) ? 0 : k, gain_out.sampler_gain);
    end
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 9'h000 : (i == 1) ? 9'h003 : (i == 2) ? 9'h1ff : 9'($urandom);
      v = (i < 3) ? 10'h3ff : 10'($urandom);
      wr(IDX_GAIN_LOW, {14'h0, c, c});
      wr(IDX_GAIN_HIGH, {14'h0, c, c});
      wr(IDX_VGA_GAIN, {22'h0, v});
      cyc(4);
      tot = int'(c) * 5625 / 16 + 351 * int'(v) + 60000;
      chk("vga code", v, gain_out.vga_code);
      chk("total gain", (tot > 420000) ? 420000 : tot, gain_out.total_gain);
      chk("clipped", tot > 420000, gain_out.clipped);
    end
    for (int k = 0; k < 3; k++) begin
      r = (k == 0) ? 6'h00 : 6'($urandom_range(40));
      s = (k < 2) ? r : r + 6'($urandom_range(20, 1));
      wr(IDX_SAMPLE, {20'h0, s, r});
      cyc(3);
      chk("ref edge", r, ref_ck);
      chk("sig edge", (s > r) ? s : r + 6'h01, sig_ck);
    end
    for (int k = 0; k < 4; k++) begin
      phs = 6'($urandom);
      wr(IDX_AFE_CTL, {20'h0, phs, k[1], k[0], 4'h0});
      cyc(4);
      chk("out phase", phs, phs_o);
      chk("drive on", 1, data_oe);
      for (int t = 0; t < 8; t++) begin
        h2 = h1;
        h1 = h0;
        h0 = adc;
        if (t > 1) begin
          chk("data out", enc(k[0] ? h1 : h2, k[1]), dout);
        end
        cyc(1);
      end
    end
    wr(IDX_AFE_CTL, 32'h1 << CTL_TRISTATE);
    cyc(3);
    chk("drive off", 0, data_oe);
    foreach (g[i]) g[i] = 9'($urandom);
    g[3] = 9'h1ff;
    wr(IDX_GAIN_LOW, {14'h0, g[1], g[0]});
    wr(IDX_GAIN_HIGH, {14'h0, g[3], g[2]});
    bus(1'b0, IDX_GAIN_HIGH, 32'h0, rdv);
    chk("gain readback", {14'h0, g[3], g[2]}, rdv);
    ef = 2'd0;
    for (int m = 0; m < 4; m++) begin
      wr(IDX_MODE_SEL, 32'(m));
      for (int f = 0; f < 3; f++) begin
        ef = (m == 1) ? {1'b0, ~ef[0]} : (m == 2) ? ((ef == 2'd2) ? 2'd0 : ef + 2'd1) : 2'd0;
        ep = (m == 1) ? ef[0] : (m == 2) ? (ef == 2'd1) : 1'b0;
        vframe(ef, ep);
        for (int l = 0; l < 3; l++) begin
          line(p);
          ep = (m == 1) ? ep : ~ep;
          chk("line pattern", ep, p);
        end
      end
    end
    wr(IDX_CLAMP_LVL, 32'h5a);
    wr(IDX_OPR_MODE, 32'h1 << OPR_CLAMP_OFF);
    cyc(3);
    chk("clamp offset", 14'h005a, clamp_dac);
    @(posedge sys_clk);
    adc_low <= 1'b1;
    wr(IDX_CLAMP_LVL, 32'hc8);
    wr(IDX_OPR_MODE, 32'h0);
    line(p);
    d0 = clamp_dac;
    repeat (3) line(p);
    chk("clamp pull", 1, $signed(clamp_dac) > $signed(d0));
    wr(IDX_OPR_MODE, 32'h1 << OPR_RATE_LSB);
    line(p);
    d0 = clamp_dac;
    line(p);
    d1 = clamp_dac;
    line(p);
    d2 = clamp_dac;
    chk("clamp rate", 1, (d1 != d0) != (d2 != d1));
    end_of_test();
  end
endmodule : test_ccd_frontend_gain_steering
